// ---- itgs_pkg.sv ----
/*
  Shared constants for the inter-thread gating store: view codes, address
  field positions, access sizes, control-view bit positions and reset values.
  Assumes a byte address whose bits 6:3 pick the view of a 64-bit cell.
*/
package itgs_pkg;

  localparam int unsigned CELL_W      = 64;
  localparam int unsigned VIEW_LSB    = 3;
  localparam int unsigned VIEW_W      = 4;
  localparam int unsigned CELL_LSB    = 7;
  localparam int unsigned OFF_W       = 3;
  localparam int unsigned WORD_SEL    = 2;
  localparam int unsigned CTL_EMPTY   = 0;
  localparam int unsigned CTL_FULL    = 1;
  localparam int unsigned MIN_CNT_W   = 15;

  localparam logic [3:0] VIEW_BYPASS  = 4'h0;
  localparam logic [3:0] VIEW_CTL     = 4'h1;
  localparam logic [3:0] VIEW_EF_SYNC = 4'h2;
  localparam logic [3:0] VIEW_EF_TRY  = 4'h3;
  localparam logic [3:0] VIEW_PV_SYNC = 4'h4;
  localparam logic [3:0] VIEW_PV_TRY  = 4'h5;

  localparam logic [1:0] SIZE_BYTE    = 2'h0;
  localparam logic [1:0] SIZE_HALF    = 2'h1;
  localparam logic [1:0] SIZE_WORD    = 2'h2;
  localparam logic [1:0] SIZE_DWORD   = 2'h3;

  localparam logic       RST_EMPTY    = 1'h1;
  localparam logic       RST_FULL     = 1'h0;
  localparam logic [63:0] RST_DATA    = 64'h0;

  typedef enum logic {ITGS_IDLE, ITGS_ACK} itgs_phase_e;

endpackage

// ---- itgs_store.sv ----
/*
  Gating store of synchronization cells plus its completion FIFO.
  Assumes the core holds a request steady until REQ_DONE or until it
  withdraws it, and drains completions through RSP_VALID/RSP_READY.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module itgs_fifo #(
  parameter int unsigned WIDTH = 65,
  parameter int unsigned DEPTH = 16
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             ce,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int unsigned PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               wr;
    logic [PW-1:0]               rd;
    logic [PW:0]                 cnt;
    logic                        vld;
    logic [WIDTH-1:0]            dout;
  } itgs_fifo_s;

  itgs_fifo_s st;
  itgs_fifo_s next_st;
  logic       push;
  logic       pop;

  assign in_ready  = (st.cnt != (PW+1)'(DEPTH));
  // head word and valid are registered so the store's outputs are flops
  assign out_valid = st.vld;
  assign out_data  = st.dout;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == PW'(DEPTH - 1)) ? '0 : PW'(st.wr + 1'b1);
    end
    if (pop) begin
      next_st.rd = (st.rd == PW'(DEPTH - 1)) ? '0 : PW'(st.rd + 1'b1);
    end
    next_st.cnt = (PW+1)'(st.cnt + {PW'(0), push} - {PW'(0), pop});
    next_st.vld  = (next_st.cnt != '0);
    next_st.dout = next_st.mem[next_st.rd];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else if (ce) begin
      st <= next_st;
    end
  end

  chk_fifo_full_stall: assert property (@(posedge clk) disable iff (!nrst)
    (st.cnt == (PW+1)'(DEPTH)) |-> !in_ready && st.rd == st.wr)
    else $error("fifo accepts data while full");
endmodule

////////////////////////////////////////////////////////////////////////////
module itgs_store #(
  parameter int unsigned NCELLS  = 32,
  parameter int unsigned CNT_W   = 16,
  parameter bit          STORE64 = 1'b1,
  parameter int unsigned RSP_DEPTH = 16,
  parameter int unsigned AW = itgs_pkg::CELL_LSB +
                              ((NCELLS > 1) ? $clog2(NCELLS) : 1)
) (
  input  wire logic          CLK,
  input  wire logic          NRST,
  input  wire logic          CE,
  input  wire logic          REQ_VALID,
  input  wire logic          REQ_WRITE,
  input  wire logic          REQ_COND,
  input  wire logic [AW-1:0] REQ_ADDR,
  input  wire logic [1:0]    REQ_SIZE,
  input  wire logic [63:0]   REQ_WDATA,
  output logic               REQ_DONE,
  output logic               REQ_STALL,
  output logic               RSP_VALID,
  input  wire logic          RSP_READY,
  output logic [63:0]        RSP_DATA,
  output logic               RSP_FAIL
);
  localparam int unsigned IW = AW - itgs_pkg::CELL_LSB;
  localparam logic [CNT_W-1:0] CNT_MAX = '1;

  initial begin
    if (NCELLS < 1 || NCELLS > 32 || CNT_W < itgs_pkg::MIN_CNT_W ||
        CNT_W > itgs_pkg::CELL_W) begin
      $error("cell count or count width out of range");
    end
  end

  // empty and full kept apart per cell
  typedef struct packed {
    itgs_pkg::itgs_phase_e       phase;
    logic [NCELLS-1:0][63:0]     data;
    logic [NCELLS-1:0]           empty;
    logic [NCELLS-1:0]           full;
    logic                        done;
    logic                        stall;
  } itgs_state_s;

  itgs_state_s st;
  itgs_state_s next_st;

  logic [3:0]    view;
  logic [IW-1:0] idx;
  logic          hit;
  logic [2:0]    off;
  logic [63:0]   cur;
  logic          cur_empty;
  logic          cur_full;
  logic [CNT_W-1:0] cnt;
  logic          blocked;
  logic          exec;
  logic          rsp_room;
  logic          push_fail;
  logic [63:0]   push_data;
  logic [64:0]   rsp_word;

  ////////////////////////////////////////////////////////////////////////
  // byte lanes of the access, aligned down to the access size
  function automatic logic [2:0] lane_off(input logic [2:0] a,
                                          input logic [1:0] sz);
    logic [2:0] m;
    m = 3'h7 << sz;
    lane_off = a & m;
    // narrow cells ignore the word select
    if (!STORE64) begin
      lane_off[itgs_pkg::WORD_SEL] = 1'b0;
    end
  endfunction

  function automatic logic [63:0] merge(input logic [63:0] old,
                                        input logic [63:0] wd,
                                        input logic [1:0]  sz,
                                        input logic [2:0]  o);
    logic [63:0] m;
    m = (sz == itgs_pkg::SIZE_DWORD) ? 64'hFFFFFFFFFFFFFFFF :
        ((64'h1 << (6'h8 << sz)) - 64'h1);
    merge = (old & ~(m << {o, 3'h0})) | ((wd & m) << {o, 3'h0});
  endfunction

  // loads return right-justified lanes matching the store
  function automatic logic [63:0] extract(input logic [63:0] c,
                                          input logic [1:0]  sz,
                                          input logic [2:0]  o);
    logic [63:0] m;
    m = (sz == itgs_pkg::SIZE_DWORD) ? 64'hFFFFFFFFFFFFFFFF :
        ((64'h1 << (6'h8 << sz)) - 64'h1);
    extract = (c >> {o, 3'h0}) & m;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // view and cell fields of the address
  assign view = REQ_ADDR[itgs_pkg::VIEW_LSB +: itgs_pkg::VIEW_W];
  assign idx  = REQ_ADDR[itgs_pkg::CELL_LSB +: IW];
  assign hit  = ({1'b0, idx} < (IW+1)'(NCELLS));
  assign off  = lane_off(REQ_ADDR[itgs_pkg::OFF_W-1:0], REQ_SIZE);
  // one data word behind every data view
  assign cur       = hit ? st.data[idx] : itgs_pkg::RST_DATA;
  assign cur_empty = hit ? st.empty[idx] : 1'b0;
  assign cur_full  = hit ? st.full[idx] : 1'b0;
  // only the count field decides zero
  assign cnt       = cur[CNT_W-1:0];

  // no debug input: a stalled access just waits
  always_comb begin
    blocked = 1'b0;
    if (hit) begin
      unique case (view)
        itgs_pkg::VIEW_EF_SYNC: blocked = REQ_WRITE ? cur_full : cur_empty;
        itgs_pkg::VIEW_PV_SYNC: blocked = !REQ_WRITE && (cnt == '0);
        default:                blocked = 1'b0;
      endcase
    end
  end

  // no cell changes until the request is executed
  assign exec = CE && REQ_VALID && (st.phase == itgs_pkg::ITGS_IDLE) &&
                rsp_room && !blocked;

  always_comb begin
    next_st   = st;
    push_data = '0;
    push_fail = 1'b0;
    next_st.done  = 1'b0;
    next_st.stall = REQ_VALID && (st.phase == itgs_pkg::ITGS_IDLE) &&
                    !(rsp_room && !blocked);
    if (st.phase == itgs_pkg::ITGS_ACK) begin
      next_st.phase = itgs_pkg::ITGS_IDLE;
    end
    if (exec && hit) begin
      next_st.done  = 1'b1;
      next_st.phase = itgs_pkg::ITGS_ACK;
      unique case (view)
        itgs_pkg::VIEW_BYPASS: begin
          if (REQ_WRITE) begin
            next_st.data[idx] = merge(cur, REQ_WDATA, REQ_SIZE, off);
          end else begin
            push_data = extract(cur, REQ_SIZE, off);
          end
        end
        itgs_pkg::VIEW_CTL: begin
          if (REQ_WRITE) begin
            next_st.empty[idx] = REQ_WDATA[itgs_pkg::CTL_EMPTY];
            next_st.full[idx]  = REQ_WDATA[itgs_pkg::CTL_FULL];
          end else begin
            push_data[itgs_pkg::CTL_EMPTY] = cur_empty;
            push_data[itgs_pkg::CTL_FULL]  = cur_full;
          end
        end
        itgs_pkg::VIEW_EF_SYNC, itgs_pkg::VIEW_EF_TRY: begin
          // single-entry cell: one value fills or drains it
          if (REQ_WRITE) begin
            // try store to a full cell is dropped
            // conditional store fails only on full
            if (cur_full) begin
              push_fail = REQ_COND;
            end else begin
              next_st.data[idx]  = merge(cur, REQ_WDATA, REQ_SIZE, off);
              next_st.full[idx]  = 1'b1;
              next_st.empty[idx] = 1'b0;
            end
          end else if (!cur_empty) begin
            // empty try load leaves push_data at zero
            push_data          = extract(cur, REQ_SIZE, off);
            next_st.empty[idx] = 1'b1;
            next_st.full[idx]  = 1'b0;
          end
        end
        itgs_pkg::VIEW_PV_SYNC, itgs_pkg::VIEW_PV_TRY: begin
          if (REQ_WRITE) begin
            if (cnt != CNT_MAX) begin
              next_st.data[idx][CNT_W-1:0] = CNT_W'(cnt + 1'b1);
            end
          end else begin
            push_data = extract(cur, REQ_SIZE, off);
            if (cnt != '0) begin
              next_st.data[idx][CNT_W-1:0] = CNT_W'(cnt - 1'b1);
            end
          end
        end
        // reserved views complete with no effect
        default: push_data = '0;
      endcase
    end else if (exec) begin
      // unmapped cells complete as reserved
      next_st.done  = 1'b1;
      next_st.phase = itgs_pkg::ITGS_ACK;
    end
  end

  always_ff @(posedge CLK) begin
    if (!NRST) begin
      st.phase <= itgs_pkg::ITGS_IDLE;
      st.data  <= {NCELLS{itgs_pkg::RST_DATA}};
      st.empty <= {NCELLS{itgs_pkg::RST_EMPTY}};
      st.full  <= {NCELLS{itgs_pkg::RST_FULL}};
      st.done  <= 1'b0;
      st.stall <= 1'b0;
    end else if (CE) begin
      st <= next_st;
    end
  end

  assign REQ_DONE  = st.done;
  assign REQ_STALL = st.stall;
  assign rsp_word  = {push_fail, push_data};

  ////////////////////////////////////////////////////////////////////////
  // completion queue: a slow consumer back-pressures execution
  itgs_fifo #(
    .WIDTH (65),
    .DEPTH (RSP_DEPTH)
  ) u_rsp (
    .clk       (CLK),
    .nrst      (NRST),
    .ce        (CE),
    .in_valid  (exec),
    .in_ready  (rsp_room),
    .in_data   (rsp_word),
    .out_valid (RSP_VALID),
    .out_ready (RSP_READY),
    .out_data  ({RSP_FAIL, RSP_DATA})
  );

  ////////////////////////////////////////////////////////////////////////
  chk_done_single: assert property (@(posedge CLK) disable iff (!NRST)
    REQ_DONE && CE |=> !REQ_DONE)
    else $error("completion held longer than one cycle");

  chk_sync_load_wait: assert property (@(posedge CLK) disable iff (!NRST)
    CE && REQ_VALID && hit && !REQ_WRITE && cur_empty &&
    view == itgs_pkg::VIEW_EF_SYNC |=> !REQ_DONE)
    else $error("synchronized load of empty cell completed");

  chk_sync_store_wait: assert property (@(posedge CLK) disable iff (!NRST)
    CE && REQ_VALID && hit && REQ_WRITE && cur_full &&
    view == itgs_pkg::VIEW_EF_SYNC |=> !REQ_DONE)
    else $error("synchronized store to full cell completed");

  chk_try_load_zero: assert property (@(posedge CLK) disable iff (!NRST)
    exec && hit && !REQ_WRITE && cur_empty &&
    view == itgs_pkg::VIEW_EF_TRY |-> push_data == '0)
    else $error("try load of empty cell returned data");

  chk_cond_fail_full: assert property (@(posedge CLK) disable iff (!NRST)
    exec && hit && REQ_WRITE && REQ_COND && view == itgs_pkg::VIEW_EF_TRY
    |-> push_fail == cur_full)
    else $error("conditional store result disagrees with full flag");

  chk_sem_decrement: assert property (@(posedge CLK) disable iff (!NRST)
    exec && hit && !REQ_WRITE && cnt != '0 &&
    view == itgs_pkg::VIEW_PV_SYNC
    |=> st.data[$past(idx)][CNT_W-1:0] == CNT_W'($past(cnt) - 1'b1))
    else $error("semaphore load did not decrement once");

  chk_sem_saturate: assert property (@(posedge CLK) disable iff (!NRST)
    exec && hit && REQ_WRITE && cnt == CNT_MAX &&
    (view == itgs_pkg::VIEW_PV_SYNC || view == itgs_pkg::VIEW_PV_TRY)
    |=> st.data[$past(idx)][CNT_W-1:0] == CNT_MAX)
    else $error("semaphore count wrapped");

  chk_sem_flags: assert property (@(posedge CLK) disable iff (!NRST)
    exec && (view == itgs_pkg::VIEW_PV_SYNC ||
    view == itgs_pkg::VIEW_PV_TRY || view == itgs_pkg::VIEW_BYPASS)
    |=> $stable(st.empty) && $stable(st.full))
    else $error("semaphore or bypass access changed flags");

  chk_withdraw_quiet: assert property (@(posedge CLK) disable iff (!NRST)
    !exec |=> $stable(st.data) && $stable(st.empty) &&
    $stable(st.full))
    else $error("cell state changed without an executed access");
endmodule

// ---- itgs_core_sink.sv ----
/*
  Completion side of the core model: drains the store's response FIFO and
  keeps the last popped completion for the bench to compare.
  Assumes one clock and a synchronous active-low reset shared with the store.
*/
`timescale 1ns/1ps

module itgs_core_sink (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        hold,
  input  wire logic        rsp_valid,
  output logic             rsp_ready,
  input  wire logic [63:0] rsp_data,
  input  wire logic        rsp_fail,
  output logic [31:0]      pops,
  output logic [63:0]      last_data,
  output logic             last_fail
);
  // hold lets the bench stall the core so the completion FIFO backs up
  assign rsp_ready = ~hold;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      pops      <= 32'h0;
      last_data <= 64'h0;
      last_fail <= 1'h0;
    end else if (rsp_valid && rsp_ready) begin
      pops      <= pops + 32'h1;
      last_data <= rsp_data;
      last_fail <= rsp_fail;
    end
  end
endmodule

// ---- tb_top.sv ----
/*
  Self-checking bench for the gating store: load/store tasks on the request
  handshake, completions taken through the core sink model.
  Assumes the default 32-cell, 16-bit count, 64-bit cell configuration.
*/
`timescale 1ns/1ps

module tb_top;
  localparam logic [3:0] BYP = itgs_pkg::VIEW_BYPASS;
  localparam logic [3:0] CTL = itgs_pkg::VIEW_CTL;
  localparam logic [3:0] EFS = itgs_pkg::VIEW_EF_SYNC;
  localparam logic [3:0] EFT = itgs_pkg::VIEW_EF_TRY;
  localparam logic [3:0] PVS = itgs_pkg::VIEW_PV_SYNC;
  localparam logic [3:0] PVT = itgs_pkg::VIEW_PV_TRY;
  localparam logic [1:0] DW  = itgs_pkg::SIZE_DWORD;
  localparam logic [1:0] SW  = itgs_pkg::SIZE_WORD;
  localparam logic [1:0] SH  = itgs_pkg::SIZE_HALF;
  localparam logic [1:0] SB  = itgs_pkg::SIZE_BYTE;

  logic        clk, nrst, req_valid, req_write, req_cond, req_done;
  logic        req_stall, rsp_valid, rsp_ready, rsp_fail, hold, lf, f;
  logic [11:0] req_addr;
  logic [1:0]  req_size;
  logic [63:0] req_wdata, rsp_data, ld, d;
  logic [31:0] pops, p0;
  logic        ce;
  int          err_total, checks, cyc, n;

  itgs_store dut (
    .CLK(clk), .NRST(nrst), .CE(ce), .REQ_VALID(req_valid),
    .REQ_WRITE(req_write), .REQ_COND(req_cond), .REQ_ADDR(req_addr),
    .REQ_SIZE(req_size), .REQ_WDATA(req_wdata), .REQ_DONE(req_done),
    .REQ_STALL(req_stall), .RSP_VALID(rsp_valid), .RSP_READY(rsp_ready),
    .RSP_DATA(rsp_data), .RSP_FAIL(rsp_fail)
  );

  itgs_core_sink core (
    .clk(clk), .nrst(nrst), .hold(hold), .rsp_valid(rsp_valid),
    .rsp_ready(rsp_ready), .rsp_data(rsp_data), .rsp_fail(rsp_fail),
    .pops(pops), .last_data(ld), .last_fail(lf)
  );

  always #2 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  function automatic logic [11:0] ad(input logic [4:0] c,
                                     input logic [3:0] v);
    return {c, v, 3'h0};
  endfunction

  task automatic put(input logic w, input logic c, input logic [11:0] a,
                     input logic [1:0] sz, input logic [63:0] wd);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = w;
    req_cond  = c;
    req_addr  = a;
    req_size  = sz;
    req_wdata = wd;
  endtask

  // request is dropped in the cycle done is high, so it never re-executes
  task automatic issue(input logic w, input logic c, input logic [11:0] a,
                       input logic [1:0] sz, input logic [63:0] wd);
    put(w, c, a, sz, wd);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (req_done !== 1'b1 && n < 50);
    req_valid = 1'b0;
    chk(64'(req_done), 64'h1);
  endtask

  task automatic acc(input logic w, input logic c, input logic [11:0] a,
                     input logic [1:0] sz, input logic [63:0] wd,
                     output logic [63:0] rd, output logic fl);
    logic [31:0] p;
    p = pops;
    issue(w, c, a, sz, wd);
    n = 0;
    while (pops === p && n < 50) begin
      @(negedge clk);
      n++;
    end
    chk(64'(pops), 64'(p + 32'h1));
    rd = ld;
    fl = lf;
  endtask

  task automatic rd(input logic [11:0] a, input logic [1:0] sz,
                    input logic [63:0] e);
    acc(1'b0, 1'b0, a, sz, 64'h0, d, f);
    chk(d, e);
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] wd);
    acc(1'b1, 1'b0, a, DW, wd, d, f);
  endtask

  // a blocked request must not complete, and withdrawing it is harmless
  task automatic stall(input logic w, input logic [11:0] a);
    logic seen;
    seen = 1'b0;
    put(w, 1'b0, a, DW, 64'h0);
    repeat (4) begin
      @(negedge clk);
      seen = seen | req_done;
    end
    chk(64'(req_stall), 64'h1);
    chk(64'(seen), 64'h0);
    req_valid = 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      err_total++;
      test_done();
    end
  end

  initial begin
    clk = 0; nrst = 0; hold = 0; req_valid = 0; req_write = 0; ce = 1;
    req_cond = 0; req_addr = 12'h0; req_size = DW; req_wdata = 64'h0;
    err_total = 0; checks = 0; cyc = 0;
    repeat (3) @(negedge clk);
    nrst = 1;
    rd(ad(5'h0, CTL), DW, 64'h1);
    stall(1'b0, ad(5'h0, EFS));
    rd(ad(5'h0, CTL), DW, 64'h1);
    wr(ad(5'h0, EFS), 64'hA5A5_0000_1234_5678);
    rd(ad(5'h0, CTL), DW, 64'h2);
    stall(1'b1, ad(5'h0, EFS));
    rd(ad(5'h0, BYP), DW, 64'hA5A5_0000_1234_5678);
    rd(ad(5'h0, EFS), DW, 64'hA5A5_0000_1234_5678);
    rd(ad(5'h0, CTL), DW, 64'h1);
    rd(ad(5'h0, EFT), DW, 64'h0);
    wr(ad(5'h0, EFT), 64'h11);
    acc(1'b1, 1'b1, ad(5'h0, EFT), DW, 64'h22, d, f);
    chk(64'(f), 64'h1);
    rd(ad(5'h0, BYP), DW, 64'h11);
    rd(ad(5'h0, EFT), DW, 64'h11);
    acc(1'b1, 1'b1, ad(5'h0, EFT), DW, 64'h33, d, f);
    chk(64'(f), 64'h0);
    acc(1'b1, 1'b0, ad(5'h0, EFT), DW, 64'h44, d, f);
    chk(64'(f), 64'h0);
    rd(ad(5'h0, BYP), DW, 64'h33);
    wr(ad(5'h0, CTL), 64'h0);
    rd(ad(5'h0, CTL), DW, 64'h0);
    // semaphore on cell 1, flags cleared first as software must
    wr(ad(5'h1, CTL), 64'h0);
    rd(ad(5'h1, PVT), DW, 64'h0);
    stall(1'b0, ad(5'h1, PVS));
    for (int i = 0; i < 3; i++) begin
      wr(ad(5'h1, PVS), 64'hFF);
    end
    rd(ad(5'h1, PVS), DW, 64'h3);
    rd(ad(5'h1, PVS), DW, 64'h2);
    rd(ad(5'h1, PVT), DW, 64'h1);
    rd(ad(5'h1, PVT), DW, 64'h0);
    rd(ad(5'h1, BYP), DW, 64'h0);
    rd(ad(5'h1, CTL), DW, 64'h0);
    wr(ad(5'h1, BYP), 64'hFFFF);
    acc(1'b1, 1'b0, ad(5'h1, PVT), DW, 64'h0, d, f);
    chk(64'(f), 64'h0);
    rd(ad(5'h1, BYP), DW, 64'hFFFF);
    wr(ad(5'h1, BYP), 64'h1_0000);
    stall(1'b0, ad(5'h1, PVS));
    rd(ad(5'h1, BYP), DW, 64'h1_0000);
    // reserved views: complete, read zero, touch nothing
    for (int v = 6; v < 16; v++) begin
      wr(ad(5'h2, 4'(v)), 64'hFF);
      rd(ad(5'h2, 4'(v)), DW, 64'h0);
    end
    rd(ad(5'h2, BYP), DW, 64'h0);
    rd(ad(5'h2, CTL), DW, 64'h1);
    // sub-width lanes, little-endian within the cell
    acc(1'b1, 1'b0, ad(5'h3, BYP) | 12'h3, SB, 64'hC3, d, f);
    rd(ad(5'h3, BYP) | 12'h3, SB, 64'hC3);
    acc(1'b1, 1'b0, ad(5'h3, BYP) | 12'h4, SW, 64'h89AB_CDEF, d, f);
    rd(ad(5'h3, BYP) | 12'h4, SW, 64'h89AB_CDEF);
    rd(ad(5'h3, BYP), DW, 64'h89AB_CDEF_C300_0000);
    acc(1'b1, 1'b0, ad(5'h3, EFS), SH, 64'h5A, d, f);
    rd(ad(5'h3, CTL), DW, 64'h2);
    rd(ad(5'h3, BYP), DW, 64'h89AB_CDEF_C300_005A);
    // completion FIFO: fill while the core stalls, then drain
    p0 = pops;
    hold = 1'b1;
    for (int i = 0; i < 16; i++) begin
      issue(1'b1, 1'b0, ad(5'h4, BYP), DW, 64'(i));
    end
    stall(1'b1, ad(5'h4, BYP));
    @(negedge clk);
    hold = 1'b0;
    repeat (40) @(negedge clk);
    chk(64'(pops), 64'(p0 + 32'h10));
    // clock enable low: a request neither completes nor writes
    ce = 1'b0;
    put(1'b1, 1'b0, ad(5'h4, BYP), DW, 64'h55);
    repeat (3) @(negedge clk);
    chk(64'(req_done), 64'h0);
    req_valid = 1'b0;
    @(negedge clk);
    ce = 1'b1;
    rd(ad(5'h4, BYP), DW, 64'hF);
    // a second reset returns every cell to its reset state
    nrst = 1'b0;
    repeat (3) @(negedge clk);
    nrst = 1'b1;
    rd(ad(5'h0, CTL), DW, 64'h1);
    rd(ad(5'h4, BYP), DW, 64'h0);
    test_done();
  end
endmodule
